// [common/msrs_pkg.sv]
// Constants and types for the modem status and register select block
package msrs_pkg;

  // Register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFF_MODEM_STATUS   = 4'h0;  // read: status, write: selector
  localparam logic [3:0] OFF_SCRATCH        = 4'h1;
  localparam logic [3:0] OFF_DIV_LOW        = 4'h2;
  localparam logic [3:0] OFF_DIV_HIGH       = 4'h3;
  localparam logic [3:0] OFF_TX_SPACE       = 4'h4;
  localparam logic [3:0] OFF_RX_FILL        = 4'h5;
  localparam logic [3:0] OFF_MODEM_CONTROL  = 4'h6;
  localparam logic [3:0] OFF_INT_STATUS     = 4'h7;
  localparam logic [3:0] OFF_INT_MASK       = 4'h8;

  // Modem status bit positions
  localparam int unsigned MS_DCTS = 0;
  localparam int unsigned MS_DDSR = 1;
  localparam int unsigned MS_TERI = 2;
  localparam int unsigned MS_DDCD = 3;

  // Modem control bit positions
  localparam int unsigned MC_DTR  = 0;
  localparam int unsigned MC_RTS  = 1;
  localparam int unsigned MC_OUT1 = 2;
  localparam int unsigned MC_OUT2 = 3;
  localparam int unsigned MC_LOOP = 4;
  localparam int unsigned MC_W    = 5;

  // Selector field positions
  localparam int unsigned SEL_CNT_BIT = 0;
  localparam int unsigned SEL_SET_LO  = 1;
  localparam int unsigned SEL_W       = 3;

  // Register set codes in selector bits 2:1
  typedef enum logic [1:0] {
    MSRS_SET_GENERAL = 2'b00,
    MSRS_SET_FIRST   = 2'b01,
    MSRS_SET_SECOND  = 2'b10,
    MSRS_SET_RSVD    = 2'b11
  } msrs_set_e;

  // Values after reset
  localparam logic [7:0]      RST_BYTE   = 8'h00;
  localparam logic [3:0]      RST_NIB    = 4'h0;
  localparam logic [SEL_W-1:0] RST_SEL   = 3'h0;
  localparam logic [MC_W-1:0] RST_MCTL   = 5'h00;
  localparam logic [3:0]      RST_PINS_N = 4'hf;  // idle handshake pins are high

  // Synchroniser depth in cycles
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// [verilog/msrs_sync.sv]
// Two-stage synchroniser for the modem handshake pins
`timescale 1ns/1ps
module msrs_sync
  import msrs_pkg::*;
#(
  parameter int unsigned       WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk) begin
        if (srst) begin
          meta[gi]     <= RST_VAL[gi];
          sync_out[gi] <= RST_VAL[gi];
        end else begin
          meta[gi]     <= async_in[gi];
          sync_out[gi] <= meta[gi];
        end
      end
    end
  endgenerate

endmodule

// [verilog/msrs_regs.sv]
// Modem status sensing, register set selector, scratch, divisor and level counts
//
// How it works
// - Shared address: reads return modem status, writes load the feature selector.
// - Carrier, DSR and CTS changes in either direction set status bits 3, 1, 0.
// - Every read of modem status clears its change flags, except any set by a change in that same cycle.
// - Bit 7 is inverted carrier pin, or user output two in loopback.
// - Bit 6 is inverted ring pin, or user output one in loopback.
// - Bit 5 is inverted DSR pin, or the DTR control in loopback.
// - Bit 4 is inverted CTS pin, or the RTS control in loopback.
// - Ring change flag sets only when the ring pin rises low to high.
// - Any set change flag raises the modem status interrupt request.
// - The feature selector is write-only; its address reads modem status.
// - Selector bits 2:1 pick general, first extra or second extra set.
// - Selector bit 0 enables reading of the two level counters.
// - Counters are reachable only while selector bits 2:1 are both zero.
// - Scratch byte stores eight bits and reads them back unchanged.
// - High and low divisor latches form the sixteen-bit baud divisor.
// - Transmit level count reads free transmit FIFO locations, read-only.
// - Receive level count reads characters held in receive FIFO, read-only.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module msrs_regs
  import msrs_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,

  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,

  // Interrupts
  output logic                   irq,
  output logic                   modem_int_req,

  // Modem handshake pins, active low
  input  wire logic              cd_n,
  input  wire logic              ri_n,
  input  wire logic              dsr_n,
  input  wire logic              cts_n,
  output logic                   dtr_n,
  output logic                   rts_n,
  output logic                   user_output_one_n,
  output logic                   user_output_two_n,

  // FIFO level inputs
  input  wire logic [7:0]        transmit_space_count,
  input  wire logic [7:0]        receive_fill_count,

  // Configuration outputs
  output logic [15:0]            divisor,
  output logic [1:0]             reg_set_sel,
  output logic                   counter_access,
  output logic                   loopback
);

  // State of the block, apart from the pin synchroniser stages
  typedef struct packed {
    logic              primed;
    logic [3:0]        prev_pin;
    logic [3:0]        delta;
    logic [SEL_W-1:0]  extra_feature_selector;
    logic [7:0]        scratch_byte;
    logic [7:0]        divisor_low_byte;
    logic [7:0]        divisor_high_byte;
    logic [MC_W-1:0]   modem_control;
    logic [3:0]        int_status;
    logic [3:0]        int_mask;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              msi;
    logic              cnt_en;
    logic [3:0]        out_n;
  } msrs_state_s;

  msrs_state_s st;
  msrs_state_s next_st;

  // Counter access decode, used by the read path and the status output
  function automatic logic cnt_open(input logic [SEL_W-1:0] sel);
    cnt_open = sel[SEL_CNT_BIT] &&
               (msrs_set_e'(sel[SEL_SET_LO +: 2]) == MSRS_SET_GENERAL);
  endfunction

  // Synchronised pins, ordered {cd, ri, dsr, cts}
  logic [3:0] pins_sync;

  msrs_sync #(
    .WIDTH   (4),
    .RST_VAL (RST_PINS_N)
  ) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({cd_n, ri_n, dsr_n, cts_n}),
    .sync_out (pins_sync)
  );

  // Effective pin levels and modem status read value
  logic [3:0]        pin_lvl;
  logic [3:0]        chg;
  logic [7:0]        status_val;
  logic [DATA_W-1:0] rd_val;
  logic              rd_status;

  always_comb begin
    // Loopback feeds control bits back as if they were the pins
    if (st.modem_control[MC_LOOP]) begin
      pin_lvl = ~{st.modem_control[MC_OUT2],
                  st.modem_control[MC_OUT1],
                  st.modem_control[MC_DTR],
                  st.modem_control[MC_RTS]};
    end else begin
      pin_lvl = pins_sync;
    end

    // Change detection, skipped on the first cycle after reset
    chg = 4'h0;
    if (st.primed) begin
      chg[MS_DCTS] = st.prev_pin[0] ^ pin_lvl[0];
      chg[MS_DDSR] = st.prev_pin[1] ^ pin_lvl[1];
      chg[MS_TERI] = ~st.prev_pin[2] & pin_lvl[2];
      chg[MS_DDCD] = st.prev_pin[3] ^ pin_lvl[3];
    end

    // Upper nibble is the complement of the pin levels
    status_val = {~pin_lvl, st.delta};

    rd_status = rd && (addr == OFF_MODEM_STATUS);

    // Read decode; unmapped addresses read zero
    case (addr)
      OFF_MODEM_STATUS: begin
        rd_val = status_val;
      end
      OFF_SCRATCH: begin
        rd_val = st.scratch_byte;
      end
      OFF_DIV_LOW: begin
        rd_val = st.divisor_low_byte;
      end
      OFF_DIV_HIGH: begin
        rd_val = st.divisor_high_byte;
      end
      OFF_TX_SPACE: begin
        rd_val = cnt_open(st.extra_feature_selector) ? transmit_space_count : 8'h00;
      end
      OFF_RX_FILL: begin
        rd_val = cnt_open(st.extra_feature_selector) ? receive_fill_count : 8'h00;
      end
      OFF_MODEM_CONTROL: begin
        rd_val = {3'h0, st.modem_control};
      end
      OFF_INT_STATUS: begin
        rd_val = {4'h0, st.int_status};
      end
      OFF_INT_MASK: begin
        rd_val = {4'h0, st.int_mask};
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // Next state
  always_comb begin
    next_st = st;

    next_st.primed   = 1'b1;
    next_st.prev_pin = pin_lvl;

    // Read data stand for one cycle only
    next_st.rdata = rd ? rd_val : 8'h00;

    // Change flags: read clears, a new change in the same cycle wins
    if (rd_status) begin
      next_st.delta = 4'h0;
    end
    next_st.delta = next_st.delta | chg;

    // Sticky interrupt status, write one to clear, set wins
    if (wr && (addr == OFF_INT_STATUS)) begin
      next_st.int_status = st.int_status & ~wdata[3:0];
    end
    next_st.int_status = next_st.int_status | chg;

    // Register writes
    if (wr) begin
      case (addr)
        OFF_MODEM_STATUS: begin
          next_st.extra_feature_selector = wdata[SEL_W-1:0];
        end
        OFF_SCRATCH: begin
          next_st.scratch_byte = wdata;
        end
        OFF_DIV_LOW: begin
          next_st.divisor_low_byte = wdata;
        end
        OFF_DIV_HIGH: begin
          next_st.divisor_high_byte = wdata;
        end
        OFF_MODEM_CONTROL: begin
          next_st.modem_control = wdata[MC_W-1:0];
        end
        OFF_INT_MASK: begin
          next_st.int_mask = wdata[3:0];
        end
        default: begin
          next_st.scratch_byte = st.scratch_byte;
        end
      endcase
    end

    // Registered outputs
    next_st.msi    = |next_st.delta;
    next_st.irq    = |(next_st.int_status & next_st.int_mask);
    next_st.cnt_en = cnt_open(next_st.extra_feature_selector);

    // Control pins held inactive in loopback
    if (next_st.modem_control[MC_LOOP]) begin
      next_st.out_n = 4'hf;
    end else begin
      next_st.out_n = ~{next_st.modem_control[MC_OUT2],
                        next_st.modem_control[MC_OUT1],
                        next_st.modem_control[MC_RTS],
                        next_st.modem_control[MC_DTR]};
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st.primed                 <= 1'b0;
      st.prev_pin               <= RST_PINS_N;
      st.delta                  <= RST_NIB;
      st.extra_feature_selector <= RST_SEL;
      st.scratch_byte           <= RST_BYTE;
      st.divisor_low_byte       <= RST_BYTE;
      st.divisor_high_byte      <= RST_BYTE;
      st.modem_control          <= RST_MCTL;
      st.int_status             <= RST_NIB;
      st.int_mask               <= RST_NIB;
      st.rdata                  <= RST_BYTE;
      st.irq                    <= 1'b0;
      st.msi                    <= 1'b0;
      st.cnt_en                 <= 1'b0;
      st.out_n                  <= RST_PINS_N;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign rdata             = st.rdata;
  assign irq               = st.irq;
  assign modem_int_req     = st.msi;
  assign divisor           = {st.divisor_high_byte, st.divisor_low_byte};
  assign reg_set_sel       = st.extra_feature_selector[SEL_SET_LO +: 2];
  assign counter_access    = st.cnt_en;
  assign loopback          = st.modem_control[MC_LOOP];
  assign dtr_n             = st.out_n[0];
  assign rts_n             = st.out_n[1];
  assign user_output_one_n = st.out_n[2];
  assign user_output_two_n = st.out_n[3];

endmodule

// [verif/msrs_modem_model.sv]
// Behavioural modem that drives the handshake pins
`timescale 1ns/1ps
module msrs_modem_model #(
  parameter realtime DLY = 1.3
) (
  // Asserted-high line requests
  input  wire logic [3:0] line_req,
  // Handshake pins, active low, idle high
  output logic            cd_n,
  output logic            ri_n,
  output logic            dsr_n,
  output logic            cts_n
);
  logic [3:0] pins_n = 4'hf;
  // Pins move off the clock edge, unrelated to it
  always @(line_req) pins_n <= #DLY ~line_req;
  assign {cd_n, ri_n, dsr_n, cts_n} = pins_n;
endmodule

// [verif/msrs_regs_monitor.sv]
// Assertion checker for the register block ports
`timescale 1ns/1ps
module msrs_regs_monitor
  import msrs_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              modem_int_req,
  input wire logic              cd_n,
  input wire logic              ri_n,
  input wire logic              dsr_n,
  input wire logic              cts_n,
  input wire logic [7:0]        transmit_space_count,
  input wire logic [7:0]        receive_fill_count,
  input wire logic [15:0]       divisor,
  input wire logic [1:0]        reg_set_sel,
  input wire logic              counter_access,
  input wire logic              loopback
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire [3:0] pins_n = {cd_n, ri_n, dsr_n, cts_n};
  wire       st_rd  = rd && addr == OFF_MODEM_STATUS;
  wire       mc_wr  = wr && addr == OFF_MODEM_CONTROL;
  // Cycles since any status source last moved
  logic [4:0] seen_q;
  logic [2:0] calm;
  always_ff @(posedge clk) begin
    seen_q <= {loopback, pins_n};
    if (srst || mc_wr || seen_q != {loopback, pins_n}) begin
      calm <= 3'h0;
    end else if (calm != 3'h4) begin
      calm <= calm + 3'h1;
    end
  end
  a_sel_write: assert property (wr && addr == OFF_MODEM_STATUS |=>
    reg_set_sel == $past(wdata[2:1])) else $error("selector field not taken");
  a_cnt_gate: assert property (wr && addr == OFF_MODEM_STATUS |=>
    counter_access == ($past(wdata[0]) && $past(wdata[2:1]) == 2'b00))
    else $error("counter gate wrong");
  a_tx_read: assert property (rd && addr == OFF_TX_SPACE && counter_access |=>
    rdata == $past(transmit_space_count)) else $error("transmit count wrong");
  a_rx_read: assert property (rd && addr == OFF_RX_FILL && counter_access |=>
    rdata == $past(receive_fill_count)) else $error("receive count wrong");
  a_cnt_closed: assert property (rd && !counter_access &&
    (addr == OFF_TX_SPACE || addr == OFF_RX_FILL) |=> rdata == 8'h00)
    else $error("closed counter readable");
  a_div_form: assert property (wr && addr == OFF_DIV_LOW |=>
    divisor[7:0] == $past(wdata) && $stable(divisor[15:8])) else $error("divisor wrong");
  a_scratch_back: assert property (wr && addr == OFF_SCRATCH ##1 rd && addr == OFF_SCRATCH
    |=> rdata == $past(wdata, 2)) else $error("scratch not returned");
  a_live_level: assert property (st_rd && !loopback && calm == 3'h4 |=>
    rdata[7:4] == ~$past(pins_n)) else $error("status levels wrong");
  a_read_clears: assert property (st_rd && calm == 3'h4 |=> !modem_int_req)
    else $error("flags kept after read");
  a_int_flags: assert property (st_rd && calm == 3'h4 |=>
    (rdata[3:0] != 4'h0) == $past(modem_int_req)) else $error("request disagrees");
  a_no_repeat: assert property (calm == 3'h4 && !modem_int_req |=> !modem_int_req)
    else $error("change seen twice");
  c_flag_read: cover property (st_rd && modem_int_req);
  c_cnt_read: cover property (rd && addr == OFF_TX_SPACE && counter_access);
  c_loop_read: cover property (st_rd && loopback);
endmodule

bind msrs_regs msrs_regs_monitor mon_u (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .modem_int_req(modem_int_req), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n),
  .transmit_space_count(transmit_space_count), .receive_fill_count(receive_fill_count),
  .divisor(divisor), .reg_set_sel(reg_set_sel), .counter_access(counter_access),
  .loopback(loopback)
);

// [verif/msrs_regs_tb_top.sv]
// Self-checking testbench for the register block
`timescale 1ns/1ps
module msrs_regs_tb_top
  import msrs_pkg::*;
;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [7:0]        tx_sp = 8'h5a;
  logic [7:0]        rx_fl = 8'h21;
  logic [3:0]        line_req = 4'h0;
  logic [DATA_W-1:0] rdata;
  logic [15:0]       div;
  logic [1:0]        sel;
  logic              irq, mreq, ca, lb, cd_n, ri_n, dsr_n, cts_n, dtr_n, rts_n, o1_n, o2_n;
  int                failures = 0;
  int                check_count = 0;
  always #2.5 clk = ~clk;
  msrs_modem_model modem_u (.line_req(line_req), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n),
    .cts_n(cts_n));
  msrs_regs dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .modem_int_req(mreq), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n),
    .cts_n(cts_n), .dtr_n(dtr_n), .rts_n(rts_n), .user_output_one_n(o1_n),
    .user_output_two_n(o2_n), .transmit_space_count(tx_sp), .receive_fill_count(rx_fl),
    .divisor(div), .reg_set_sel(sel), .counter_access(ca), .loopback(lb));
  task automatic report_and_stop;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
  endtask
  task automatic idle(input int n);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    idle(1);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, a, 8'h00);
    idle(0);
    check(rdata & m, e);
  endtask
  task automatic t_pins;
    for (int j = 0; j < 4; j++) begin
      line_req[j] = 1'b1;
      idle(6);
      check(mreq, j != 2);
      rd_chk(OFF_MODEM_STATUS, {line_req, j == 2 ? 4'h0 : 4'(1 << j)}, 8'hff);
      check(mreq, 1'b0);
      line_req[j] = 1'b0;
      idle(6);
      check(mreq, 1'b1);
      rd_chk(OFF_MODEM_STATUS, {line_req, 4'(1 << j)}, 8'hff);
      rd_chk(OFF_MODEM_STATUS, 8'h00, 8'hff);
    end
  endtask
  task automatic t_irq;
    line_req[0] = 1'b1;
    idle(6);
    check({mreq, irq}, 2'b10);
    wr_reg(OFF_INT_MASK, 8'h01);
    check(irq, 1'b1);
    wr_reg(OFF_INT_STATUS, 8'h01);
    check(irq, 1'b0);
    rd_chk(OFF_MODEM_STATUS, 8'h11, 8'hff);
    wr_reg(OFF_INT_MASK, 8'h00);
    line_req[0] = 1'b0;
    idle(6);
    rd_chk(OFF_MODEM_STATUS, 8'h01, 8'hff);
  endtask
  task automatic t_loop;
    wr_reg(OFF_MODEM_CONTROL, 8'h15);
    line_req = 4'hf;
    idle(6);
    check({dtr_n, rts_n, o1_n, o2_n, lb}, 5'h1f);
    rd_chk(OFF_MODEM_STATUS, 8'h60, 8'hf0);
    wr_reg(OFF_MODEM_CONTROL, 8'h1a);
    rd_chk(OFF_MODEM_STATUS, 8'h90, 8'hf0);
    wr_reg(OFF_MODEM_CONTROL, 8'h03);
    idle(4);
    check({dtr_n, rts_n, o1_n, o2_n, lb}, 5'h06);
    rd_chk(OFF_MODEM_STATUS, 8'hf0, 8'hf0);
    line_req = 4'h0;
    wr_reg(OFF_MODEM_CONTROL, 8'h00);
    idle(6);
    rd_chk(OFF_MODEM_STATUS, 8'h00, 8'hf0);
    rd_chk(OFF_MODEM_STATUS, 8'h00, 8'hff);
  endtask
  task automatic t_select;
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFF_MODEM_STATUS, 8'hf9 | 8'(c << 1));
      check({sel, ca}, {2'(c), c == 0});
      rd_chk(OFF_TX_SPACE, c == 0 ? tx_sp : 8'h00, 8'hff);
      rd_chk(OFF_RX_FILL, c == 0 ? rx_fl : 8'h00, 8'hff);
      rd_chk(OFF_MODEM_STATUS, 8'h00, 8'hff);
    end
    wr_reg(OFF_MODEM_STATUS, 8'h01);
    wr_reg(OFF_TX_SPACE, 8'h00);
    rd_chk(OFF_TX_SPACE, tx_sp, 8'hff);
    wr_reg(OFF_MODEM_STATUS, 8'h00);
    rd_chk(OFF_RX_FILL, 8'h00, 8'hff);
  endtask
  task automatic t_regs;
    bus(1'b1, OFF_SCRATCH, 8'ha5);
    rd_chk(OFF_SCRATCH, 8'ha5, 8'hff);
    bus(1'b1, OFF_DIV_LOW, 8'h34);
    bus(1'b1, OFF_DIV_HIGH, 8'h12);
    idle(1);
    check(div, 16'h1234);
    rd_chk(OFF_DIV_HIGH, 8'h12, 8'hff);
    rd_chk(4'hf, 8'h00, 8'hff);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rd_chk(OFF_MODEM_STATUS, 8'h00, 8'hff);
    t_pins;
    t_irq;
    t_loop;
    t_select;
    t_regs;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
